// file: src/sdcp_bank_mem.sv
// sdcp_bank_mem: per-bank open/closed flags with registered read-out.
// assumes decoded open and close strobes from the command decoder.
`timescale 1ns/1ps
module sdcp_bank_mem
    import sdcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [SDCP_NUM_BANKS-1:0] open_req,
    input wire logic [SDCP_NUM_BANKS-1:0] close_req,
    output logic [SDCP_NUM_BANKS-1:0] bank_open
);
    // one flag per bank, close wins only if no open in the same cycle
    genvar g;
    generate
        for (g = 0; g < SDCP_NUM_BANKS; g++)
        begin : g_bank
            always_ff @(posedge sys_clk)
            begin
                if (!resetn)
                    bank_open[g] <= 1'b0;
                else if (open_req[g])
                    bank_open[g] <= 1'b1;
                else if (close_req[g])
                    bank_open[g] <= 1'b0;
            end
        end
    endgenerate
endmodule // sdcp_bank_mem

// file: src/sdcp_core.sv
// sdcp_core: command decode and power-state logic of a four-bank sdram.
// assumes controller drives pins synchronously to sys_clk.
// Operation
// - decode precharge, cs ras we low, cas high
// - bit ten high closes all banks
// - self refresh on cs ras cas cke low
// - self refresh ignores all but cke
// - self refresh exits on cke high
// - cke low idle enters power-down
// - nop keeps running burst going
// - cs high is deselect, like nop
// - cke low with active bank suspends clock
// - suspend ignores commands, resumes one later
// - commands sampled need previous cke high
// - read write pick bank, bit ten autoprecharge in fixed burst only
// - burst stop only in full-page burst
// - cke low in burst means suspend
`timescale 1ns/1ps
module sdcp_core
    import sdcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_sel_lo,
    input wire logic bank_sel_hi,
    input wire logic [SDCP_ADDR_W-1:0] addr,
    input wire logic full_page,
    output logic [SDCP_NUM_BANKS-1:0] bank_active,
    output logic self_refresh,
    output logic power_down,
    output logic clk_suspend,
    output logic burst_busy,
    output logic int_clk_en,
    output logic refresh_pulse,
    output logic illegal_cmd
);
    sdcp_state_t state; // power state
    sdcp_state_t next_state; // next power state
    logic cke_prev; // cke at previous edge
    logic [2:0] burst_cnt; // remaining beats
    logic burst_fp; // running burst is full page
    logic burst_ap; // running burst auto-precharges
    logic [SDCP_BANK_W-1:0] burst_bank; // bank of running burst
    logic [SDCP_NUM_BANKS-1:0] bank_open; // from bank flag store
    logic [SDCP_NUM_BANKS-1:0] open_req; // activate strobes
    logic [SDCP_NUM_BANKS-1:0] close_req; // precharge strobes

    // decode of pins
    wire [2:0] cmd = {ras_n, cas_n, we_n}; // command code
    wire [SDCP_BANK_W-1:0] bank = {bank_sel_hi, bank_sel_lo}; // target bank
    wire ap_bit = addr[SDCP_AP_BIT]; // addr_bit_ten
    wire any_open = |bank_open; // any bank active
    wire in_burst = burst_cnt != 3'h0 || burst_fp; // data burst running
    wire in_normal = state == SDCP_NORMAL; // commands may be taken
    // cke at the command edge only gates the following cycle, so it is not
    // part of the decode of ordinary commands
    wire cmd_ok = in_normal && cke_prev && !cs_n;
    wire burst_step = in_normal && cke_prev; // internal clock runs this edge
    wire dec_pre = cmd_ok && cmd == SDCP_CMD_PRE;
    wire dec_act = cmd_ok && cmd == SDCP_CMD_ACT && !bank_open[bank];
    wire dec_rw = cmd_ok && (cmd == SDCP_CMD_RD || cmd == SDCP_CMD_WR)
        && bank_open[bank];
    wire dec_bst = cmd_ok && cmd == SDCP_CMD_BST;
    wire bst_ok = dec_bst && burst_fp;
    wire dec_ref = cmd_ok && cke && cmd == SDCP_CMD_REF && !any_open;
    wire dec_sref = cmd_ok && !cke && cmd == SDCP_CMD_REF && !any_open;
    wire burst_end = burst_step && burst_cnt == 3'h1 && !burst_fp; // last beat
    wire ap_close = burst_end && burst_ap; // auto-precharge fires
    wire cke_drop = in_normal && cke_prev && !cke && !dec_sref; // cke low seen
    wire to_suspend = cke_drop && (any_open || in_burst);
    wire to_pdown = cke_drop && !any_open && !in_burst;
    wire bad_cmd = (dec_bst && !burst_fp)
        || (cmd_ok && (cmd == SDCP_CMD_RD || cmd == SDCP_CMD_WR)
        && !bank_open[bank]); // misuse flag

    // bank open and close strobes
    genvar g;
    generate
        for (g = 0; g < SDCP_NUM_BANKS; g++)
        begin : g_strobe
            assign open_req[g] = dec_act && bank == SDCP_BANK_W'(g);
            assign close_req[g] = (dec_pre && (ap_bit
                || bank == SDCP_BANK_W'(g)))
                || (ap_close && burst_bank == SDCP_BANK_W'(g));
        end
    endgenerate

    // bank flag store
    sdcp_bank_mem sdcp_bank_mem_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .open_req(open_req),
        .close_req(close_req),
        .bank_open(bank_open)
    );

    // power state transitions
    always_comb
    begin
        next_state = state;
        case (state)
            SDCP_NORMAL:
            begin
                if (dec_sref)
                    next_state = SDCP_SELF_REFRESH;
                else if (to_suspend)
                    next_state = SDCP_CLK_SUSPEND;
                else if (to_pdown)
                    next_state = SDCP_POWER_DOWN;
            end
            SDCP_SELF_REFRESH:
                if (cke) next_state = SDCP_NORMAL;
            SDCP_POWER_DOWN:
                if (cke) next_state = SDCP_NORMAL;
            SDCP_CLK_SUSPEND:
                if (cke) next_state = SDCP_NORMAL;
            default:
                next_state = SDCP_NORMAL;
        endcase
    end

    // state and cke history
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state <= SDCP_NORMAL;
            cke_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cke_prev <= cke;
        end
    end

    // burst tracker; frozen outside normal state
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            burst_cnt <= 3'h0;
            burst_fp <= 1'b0;
            burst_ap <= 1'b0;
            burst_bank <= '0;
        end
        else if (dec_rw)
        begin
            burst_cnt <= full_page ? 3'h0 : SDCP_BURST_LEN_M1;
            burst_fp <= full_page;
            burst_ap <= ap_bit && !full_page;
            burst_bank <= bank;
        end
        else if (bst_ok)
            burst_fp <= 1'b0;
        else if (burst_step && burst_cnt != 3'h0)
            burst_cnt <= burst_cnt - 3'h1;
    end

    // registered status outputs
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            bank_active <= '0;
            self_refresh <= 1'b0;
            power_down <= 1'b0;
            clk_suspend <= 1'b0;
            burst_busy <= 1'b0;
            int_clk_en <= 1'b1;
            refresh_pulse <= 1'b0;
            illegal_cmd <= 1'b0;
        end
        else
        begin
            bank_active <= (bank_open | open_req) & ~(close_req & ~open_req);
            self_refresh <= next_state == SDCP_SELF_REFRESH;
            power_down <= next_state == SDCP_POWER_DOWN;
            clk_suspend <= next_state == SDCP_CLK_SUSPEND;
            burst_busy <= in_burst;
            int_clk_en <= next_state == SDCP_NORMAL;
            refresh_pulse <= dec_ref;
            illegal_cmd <= bad_cmd;
        end
    end

    // checks
    a_pre_closes: assert property (@(posedge sys_clk) disable iff (!resetn)
        dec_pre && ap_bit && !dec_act |=> bank_open == '0)
        else $error("precharge all left a bank open");
    a_pre_decode: assert property (@(posedge sys_clk) disable iff (!resetn)
        in_normal && $past(cke) && cke && !cs_n && !ras_n && cas_n && !we_n
        |-> dec_pre)
        else $error("precharge not decoded");
    a_sref_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
        dec_sref |=> self_refresh && !int_clk_en)
        else $error("self refresh not entered");
    a_sref_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == SDCP_SELF_REFRESH && !cke |=> state == SDCP_SELF_REFRESH
        && $stable(bank_open))
        else $error("self refresh left while cke low");
    a_sref_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == SDCP_SELF_REFRESH && cke |=> in_normal)
        else $error("self refresh exit missed");
    a_pdown_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
        to_pdown |=> power_down ##0 !clk_suspend)
        else $error("power-down not entered");
    a_nop_keeps: assert property (@(posedge sys_clk) disable iff (!resetn)
        cmd_ok && cke && cmd == SDCP_CMD_NOP && burst_cnt > 3'h1
        |=> burst_cnt == $past(burst_cnt) - 3'h1)
        else $error("nop disturbed burst");
    a_desel_none: assert property (@(posedge sys_clk) disable iff (!resetn)
        cs_n |-> !dec_pre && !dec_act && !dec_rw && !dec_ref)
        else $error("deselect decoded a command");
    a_susp_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
        to_suspend |=> clk_suspend)
        else $error("clock suspend not entered");
    a_susp_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == SDCP_CLK_SUSPEND |-> !dec_rw && !dec_act && !dec_pre
        ##1 $stable(burst_cnt))
        else $error("suspend took a command");
    a_ref_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        dec_ref |-> !any_open && $past(cke) && cke)
        else $error("refresh with bank open");
    a_rw_bank: assert property (@(posedge sys_clk) disable iff (!resetn)
        dec_rw |-> bank_open[bank])
        else $error("access to closed bank");
    c_sref: cover property (@(posedge sys_clk) dec_sref ##[1:20] in_normal);
    c_pdown: cover property (@(posedge sys_clk) to_pdown);
    c_susp: cover property (@(posedge sys_clk) to_suspend && in_burst);
    c_ap: cover property (@(posedge sys_clk) ap_close);
endmodule // sdcp_core

// file: src/sdcp_pkg.sv
// sdcp_pkg: command codes, bank count, state types and timing counts
// for the sdram command and power-state decoder.
// assumes a 40 mhz sys_clk; all pin inputs already synchronous.
package sdcp_pkg;
    localparam int SDCP_NUM_BANKS = 4; // four banks
    localparam int SDCP_BANK_W = 2; // bank-select width
    localparam int SDCP_ADDR_W = 12; // address width
    localparam int SDCP_AP_BIT = 10; // addr_bit_ten position
    localparam int SDCP_CLK_PERIOD_PS = 25000; // 40 mhz period
    localparam int SDCP_BURST_LEN = 4; // fixed burst for non-full-page
    localparam logic [2:0] SDCP_BURST_LEN_M1 = 3'h3; // burst count start
    localparam logic [2:0] SDCP_CMD_ACT = 3'h3; // ras cas we = l h h
    localparam logic [2:0] SDCP_CMD_PRE = 3'h2; // l h l
    localparam logic [2:0] SDCP_CMD_WR = 3'h4; // h l l
    localparam logic [2:0] SDCP_CMD_RD = 3'h5; // h l h
    localparam logic [2:0] SDCP_CMD_MRS = 3'h0; // l l l
    localparam logic [2:0] SDCP_CMD_NOP = 3'h7; // h h h
    localparam logic [2:0] SDCP_CMD_BST = 3'h6; // h h l
    localparam logic [2:0] SDCP_CMD_REF = 3'h1; // l l h
    // power/operating state of the device
    typedef enum logic [2:0] {
        SDCP_NORMAL,
        SDCP_SELF_REFRESH,
        SDCP_POWER_DOWN,
        SDCP_CLK_SUSPEND
    } sdcp_state_t;
endpackage

// file: tb/sdcp_ctrl_model.sv
// sdcp_ctrl_model: memory controller side that drives the command pins.
// assumes the bench sets requests just after a rising sys_clk edge.
`timescale 1ns/1ps
module sdcp_ctrl_model
    import sdcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [3:0] req_cmd,
    input wire logic req_cke,
    input wire logic [1:0] req_bank,
    input wire logic [SDCP_ADDR_W-1:0] req_addr,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_sel_lo,
    output logic bank_sel_hi,
    output logic [SDCP_ADDR_W-1:0] addr
);
    logic [2:0] last = 3'h0; // strobes at the last edge
    // remember strobes so a deselect shows a changing pattern
    always @(posedge sys_clk)
        last <= {ras_n, cas_n, we_n};
    assign cke = req_cke; // held low for self refresh
    assign cs_n = req_cmd[3];
    assign {ras_n, cas_n, we_n} = req_cmd[3] ? ~last : req_cmd[2:0];
    assign {bank_sel_hi, bank_sel_lo} = req_bank;
    assign addr = req_addr;
endmodule // sdcp_ctrl_model

// file: tb/sdram_command_power_control_tb_top.sv
// bench top: drives the decoder through the controller model, checks state.
// assumes the decoder answers one cycle after a command edge.
`timescale 1ns/1ps
module sdram_command_power_control_tb_top;
    import sdcp_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] req_cmd = 4'hf; // {cs, ras, cas, we}
    logic req_cke = 1'b1;
    logic [1:0] req_bank = 2'h0;
    logic [SDCP_ADDR_W-1:0] req_addr = 12'h000;
    logic cke, cs_n, ras_n, cas_n, we_n, bank_sel_lo, bank_sel_hi;
    logic [SDCP_ADDR_W-1:0] addr;
    logic full_page = 1'b0; // fixed burst mode
    logic [3:0] bank_active;
    logic self_refresh, power_down, clk_suspend, burst_busy;
    logic int_clk_en, refresh_pulse, illegal_cmd;
    int mismatches = 0;
    int num_checks = 0;
    int n_ref, n_ill, e_banks;
    logic e_sr, e_pd, e_cs, e_bb;
    always #12.5 sys_clk = ~sys_clk;
    sdcp_ctrl_model sdcp_ctrl_model_i (.sys_clk(sys_clk), .req_cmd(req_cmd),
        .req_cke(req_cke), .req_bank(req_bank), .req_addr(req_addr), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi), .addr(addr));
    sdcp_core sdcp_core_i (.sys_clk(sys_clk), .resetn(resetn), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel_lo(bank_sel_lo),
        .bank_sel_hi(bank_sel_hi), .addr(addr), .full_page(full_page),
        .bank_active(bank_active), .self_refresh(self_refresh), .power_down(power_down),
        .clk_suspend(clk_suspend), .burst_busy(burst_busy), .int_clk_en(int_clk_en),
        .refresh_pulse(refresh_pulse), .illegal_cmd(illegal_cmd));
    // compare and count
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one request, set just after an edge
    task put(input logic [3:0] c, input logic ck, input logic [1:0] b, input logic ten);
        @(posedge sys_clk);
        #2;
        req_cmd = c;
        req_cke = ck;
        req_bank = b;
        req_addr = 12'($urandom);
        req_addr[SDCP_AP_BIT] = ten;
    endtask
    // nop for three edges, counting pulses
    task hold(input logic ck);
        n_ref = 0;
        n_ill = 0;
        repeat (3)
        begin
            @(posedge sys_clk);
            #1;
            n_ref += int'(refresh_pulse === 1'b1);
            n_ill += int'(illegal_cmd === 1'b1);
            #1;
            req_cmd = {1'b0, SDCP_CMD_NOP};
            req_cke = ck;
        end
    endtask
    // state and pulse counts against the model
    task look(input int er, input int ei);
        chk({3'h0, bank_active, burst_busy, self_refresh, power_down, clk_suspend,
            int_clk_en}, {3'h0, e_banks[3:0], e_bb, e_sr, e_pd, e_cs,
            ~(e_sr | e_pd | e_cs)});
        chk({4'h0, 4'(n_ref), 4'(n_ill)}, {4'h0, 4'(er), 4'(ei)});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
    // main sequence
    initial
    begin
        void'($urandom(61));
        {e_sr, e_pd, e_cs, e_bb} = 4'h0;
        e_banks = 0;
        repeat (2) @(posedge sys_clk);
        #2;
        resetn = 1'b1;
        hold(1'b1);
        look(0, 0);
        for (int b = 0; b < 4; b++)
        begin
            put({1'b0, SDCP_CMD_ACT}, 1'b1, 2'(b), 1'($urandom));
            hold(1'b1);
            e_banks |= 1 << b;
            look(0, 0);
        end
        for (int b = 0; b < 4; b++)
        begin
            put({1'b0, SDCP_CMD_PRE}, 1'b1, 2'(b), 1'b0);
            hold(1'b1);
            e_banks &= ~(1 << b);
            look(0, 0);
        end
        put({1'b0, SDCP_CMD_ACT}, 1'b1, 2'h2, 1'b0);
        hold(1'b1);
        e_banks = 4;
        put(4'ha, 1'b1, 2'h2, 1'b0);
        hold(1'b1);
        look(0, 0);
        put({1'b0, SDCP_CMD_REF}, 1'b1, 2'h0, 1'b0);
        hold(1'b1);
        look(0, 0);
        put({1'b0, SDCP_CMD_PRE}, 1'b1, 2'($urandom), 1'b1);
        hold(1'b1);
        e_banks = 0;
        look(0, 0);
        put({1'b0, SDCP_CMD_REF}, 1'b1, 2'h0, 1'b0);
        hold(1'b1);
        look(1, 0);
        put({1'b0, SDCP_CMD_BST}, 1'b1, 2'h0, 1'b0);
        hold(1'b1);
        look(0, 1);
        put({1'b0, SDCP_CMD_ACT}, 1'b1, 2'h0, 1'b0);
        hold(1'b0);
        e_banks = 1;
        e_cs = 1'b1;
        look(0, 0);
        put({1'b0, SDCP_CMD_PRE}, 1'b0, 2'h0, 1'b1);
        hold(1'b0);
        look(0, 0);
        hold(1'b1);
        e_cs = 1'b0;
        look(0, 0);
        put({1'b0, SDCP_CMD_PRE}, 1'b1, 2'h0, 1'b1);
        hold(1'b0);
        e_banks = 0;
        e_pd = 1'b1;
        look(0, 0);
        hold(1'b1);
        e_pd = 1'b0;
        look(0, 0);
        put({1'b0, SDCP_CMD_REF}, 1'b0, 2'h0, 1'b0);
        hold(1'b0);
        e_sr = 1'b1;
        look(0, 0);
        put({1'b0, SDCP_CMD_ACT}, 1'b0, 2'h3, 1'b0);
        hold(1'b0);
        look(0, 0);
        hold(1'b1);
        e_sr = 1'b0;
        look(0, 0);
        put({1'b0, SDCP_CMD_REF}, 1'b1, 2'h0, 1'b0);
        hold(1'b1);
        look(1, 0);
        // fixed burst read with auto-precharge closes its bank on the last beat
        put({1'b0, SDCP_CMD_ACT}, 1'b1, 2'h1, 1'b0);
        hold(1'b1);
        e_banks = 2;
        look(0, 0);
        put({1'b0, SDCP_CMD_RD}, 1'b1, 2'h1, 1'b1);
        hold(1'b1);
        e_bb = 1'b1;
        look(0, 0);
        hold(1'b1);
        e_bb = 1'b0;
        e_banks = 0;
        look(0, 0);
        // write burst frozen by cke low, resumes one cycle after cke high
        put({1'b0, SDCP_CMD_ACT}, 1'b1, 2'h0, 1'b0);
        hold(1'b1);
        put({1'b0, SDCP_CMD_WR}, 1'b1, 2'h0, 1'b0);
        hold(1'b0);
        e_banks = 1;
        e_bb = 1'b1;
        e_cs = 1'b1;
        look(0, 0);
        hold(1'b1);
        e_cs = 1'b0;
        look(0, 0);
        hold(1'b1);
        e_bb = 1'b0;
        look(0, 0);
        put({1'b0, SDCP_CMD_PRE}, 1'b1, 2'h3, 1'b1);
        hold(1'b1);
        e_banks = 0;
        look(0, 0);
        // access to a closed bank is flagged and starts no burst
        put({1'b0, SDCP_CMD_RD}, 1'b1, 2'($urandom), 1'b0);
        hold(1'b1);
        look(0, 1);
        // full-page read runs until burst stop
        full_page = 1'b1;
        put({1'b0, SDCP_CMD_ACT}, 1'b1, 2'h3, 1'b0);
        hold(1'b1);
        put({1'b0, SDCP_CMD_RD}, 1'b1, 2'h3, 1'b0);
        hold(1'b1);
        e_banks = 8;
        e_bb = 1'b1;
        look(0, 0);
        put({1'b0, SDCP_CMD_BST}, 1'b1, 2'h3, 1'b0);
        hold(1'b1);
        e_bb = 1'b0;
        look(0, 0);
        test_done();
    end
endmodule // sdram_command_power_control_tb_top
